// ### logic/asrc_defines.svh
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH

// Memory geometry
`define ASRC_ADDR_W 17
`define ASRC_DATA_W 8

// Timing in ns, worst speed grade, clock period in ns
`define ASRC_CLK_NS 25
`define ASRC_TRC_NS 150
`define ASRC_TWP_NS 100
`define ASRC_TDW_NS 80
`define ASRC_TOHZ_NS 50

// Least times round up to whole cycles; a zero time gives zero cycles
`define ASRC_CYC(ns) (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS)
`define ASRC_RD_CYC `ASRC_CYC(`ASRC_TRC_NS)
`define ASRC_WR_CYC `ASRC_CYC(`ASRC_TWP_NS)
`define ASRC_TA_CYC `ASRC_CYC(`ASRC_TOHZ_NS)

`define ASRC_CNT_W 4
`define ASRC_CNT_ZERO 4'H0
`define ASRC_CNT_ONE 4'H1

`endif

// ### logic/asrc_pkg.sv
package asrc_pkg;
   typedef enum logic [2:0] {
      ASRC_IDLE,
      ASRC_SETUP,
      ASRC_READ,
      ASRC_WRITE,
      ASRC_HOLD,
      ASRC_TURN
   } asrc_state_e;
endpackage : asrc_pkg

// ### logic/asrc_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "asrc_defines.svh"

module asrc_host
   import asrc_pkg::*;
(
   input  wire logic                    clk_sys,
   input  wire logic                    rst_b,
   input  wire logic                    reqValid,
   output logic                         reqReady,
   input  wire logic                    reqWrite,
   input  wire logic [`ASRC_ADDR_W-1:0] reqAddr,
   input  wire logic [`ASRC_DATA_W-1:0] reqData,
   output logic                         rspValid,
   output logic [`ASRC_DATA_W-1:0]      rspData,
   output logic [`ASRC_ADDR_W-1:0]      memAddr,
   output logic                         selectActiveLow_b,
   output logic                         selectActiveHigh,
   output logic                         writeStrobe_b,
   output logic                         outputGate_b,
   input  wire logic [`ASRC_DATA_W-1:0] memDataIn,
   output logic [`ASRC_DATA_W-1:0]      memDataOut,
   output logic                         memDataOe
);

   localparam logic [`ASRC_CNT_W-1:0] RD_CNT = `ASRC_CNT_W'(`ASRC_RD_CYC);
   localparam logic [`ASRC_CNT_W-1:0] WR_CNT = `ASRC_CNT_W'(`ASRC_WR_CYC);
   localparam logic [`ASRC_CNT_W-1:0] TA_CNT = `ASRC_CNT_W'(`ASRC_TA_CYC);

   logic                    rstSync1;
   logic                    rstSync2;
   asrc_state_e             state;
   asrc_state_e             next_state;
   logic [`ASRC_CNT_W-1:0]  count;
   logic                    isWrite;
   logic                    readDone;

   function automatic logic isAccess(input asrc_state_e s);
      return (s == ASRC_READ || s == ASRC_WRITE);
   endfunction : isAccess

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rstSync1 <= 1'B0;
         rstSync2 <= 1'B0;
      end else begin
         rstSync1 <= 1'B1;
         rstSync2 <= rstSync1;
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   assign reqReady = (state == ASRC_IDLE);
   assign readDone = (state == ASRC_READ && count == `ASRC_CNT_ONE);

   always_comb begin
      next_state = state;
      unique case (state)
         ASRC_IDLE:  if (reqValid) next_state = ASRC_SETUP;
         ASRC_SETUP: next_state = isWrite ? ASRC_WRITE : ASRC_READ;
         ASRC_READ:  if (count == `ASRC_CNT_ONE) next_state = ASRC_TURN;
         ASRC_WRITE: if (count == `ASRC_CNT_ONE) next_state = ASRC_HOLD;
         ASRC_HOLD:  next_state = ASRC_IDLE;
         ASRC_TURN:  if (count == `ASRC_CNT_ONE) next_state = ASRC_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstSync2) begin
      if (!rstSync2) begin
         state <= ASRC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys or negedge rstSync2) begin
      if (!rstSync2) begin
         count <= `ASRC_CNT_ZERO;
      end else if (state == ASRC_SETUP) begin
         count <= isWrite ? WR_CNT : RD_CNT;
      end else if (readDone) begin
         count <= TA_CNT;
      end else if (count != `ASRC_CNT_ZERO) begin
         count <= count - `ASRC_CNT_ONE;
      end
   end

   // ------------------------------------------------------------
   // Request capture; address moves only while deselected
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstSync2) begin
      if (!rstSync2) begin
         memAddr    <= '0;
         memDataOut <= '0;
         isWrite    <= 1'B0;
      end else if (state == ASRC_IDLE && reqValid) begin
         memAddr    <= reqAddr;
         memDataOut <= reqData;
         isWrite    <= reqWrite;
      end
   end

   // ------------------------------------------------------------
   // Memory control pins
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstSync2) begin
      if (!rstSync2) begin
         selectActiveLow_b <= 1'B1;
         selectActiveHigh  <= 1'B0;
         writeStrobe_b     <= 1'B1;
         outputGate_b      <= 1'B1;
         memDataOe         <= 1'B0;
      end else begin
         // Selects assert one cycle after address settles
         selectActiveLow_b <= !isAccess(next_state);
         selectActiveHigh  <= isAccess(next_state);
         // Strobe and selects end the write together
         writeStrobe_b     <= !(next_state == ASRC_WRITE);
         outputGate_b      <= !(next_state == ASRC_READ);
         // Data driven with gate high, one cycle past the strobe
         memDataOe         <= (next_state == ASRC_WRITE ||
                               next_state == ASRC_HOLD);
      end
   end

   // ------------------------------------------------------------
   // Read return
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstSync2) begin
      if (!rstSync2) begin
         rspValid <= 1'B0;
         rspData  <= '0;
      end else begin
         rspValid <= readDone;
         if (readDone) begin
            rspData <= memDataIn;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   read_strobe_high_a: assert property (
      @(posedge clk_sys) disable iff (!rstSync2)
      !outputGate_b |-> writeStrobe_b)
      else $error("write strobe low during read");

   addr_stable_sel_a: assert property (
      @(posedge clk_sys) disable iff (!rstSync2)
      !$stable(memAddr) |-> (selectActiveLow_b || !selectActiveHigh ||
                             writeStrobe_b))
      else $error("address moved while fully active");

   no_contention_a: assert property (
      @(posedge clk_sys) disable iff (!rstSync2)
      memDataOe |-> outputGate_b)
      else $error("data driven with output gate low");

   write_overlap_a: assert property (
      @(posedge clk_sys) disable iff (!rstSync2)
      $fell(writeStrobe_b) |-> !selectActiveLow_b && selectActiveHigh
                               && memDataOe)
      else $error("write strobe without selects");

   write_width_a: assert property (
      @(posedge clk_sys) disable iff (!rstSync2)
      $fell(writeStrobe_b) |-> !writeStrobe_b [*4] ##1
         (writeStrobe_b && selectActiveLow_b && !selectActiveHigh &&
          memDataOe))
      else $error("write end order or width wrong");

   gate_float_a: assert property (
      @(posedge clk_sys) disable iff (!rstSync2)
      (writeStrobe_b && selectActiveLow_b) |-> outputGate_b)
      else $error("output gate low while idle");

   read_return_a: assert property (
      @(posedge clk_sys) disable iff (!rstSync2)
      $fell(outputGate_b) |-> ##6 rspValid)
      else $error("read answer late");

   strobe_float_a: assert property (
      @(posedge clk_sys) disable iff (!rstSync2)
      !writeStrobe_b |-> outputGate_b)
      else $error("gate low with strobe low");

   hold_release_a: assert property (
      @(posedge clk_sys) disable iff (!rstSync2)
      $rose(writeStrobe_b) |-> memDataOe ##1 !memDataOe)
      else $error("write data not held one cycle past strobe");

   turn_gap_a: assert property (
      @(posedge clk_sys) disable iff (!rstSync2)
      $rose(outputGate_b) |-> !memDataOe [*2])
      else $error("data driven during read turnaround");

   addr_setup_a: assert property (
      @(posedge clk_sys) disable iff (!rstSync2)
      $fell(selectActiveLow_b) |-> $stable(memAddr))
      else $error("address moved as select asserted");

   rsp_pulse_a: assert property (
      @(posedge clk_sys) disable iff (!rstSync2)
      rspValid |=> !rspValid)
      else $error("read answer longer than one cycle");

endmodule : asrc_host
`default_nettype wire

// ### verification/asrc_sram_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "asrc_defines.svh"
module asrc_sram_model (
   input  wire logic [`ASRC_ADDR_W-1:0] addr,
   input  wire logic                    selLow_b,
   input  wire logic                    selHigh,
   input  wire logic                    we_b,
   input  wire logic                    oe_b,
   input  wire logic [`ASRC_DATA_W-1:0] hostData,
   input  wire logic                    hostOe,
   output logic      [`ASRC_DATA_W-1:0] bus,
   output logic                         clash
);
   logic [`ASRC_DATA_W-1:0] mem [logic [`ASRC_ADDR_W-1:0]];
   logic [`ASRC_DATA_W-1:0] last = 8'H00;
   logic                    sel;
   logic                    wrAct;
   logic                    rdBlk = 1'b0;
   logic                    drive;
   assign sel   = !selLow_b && selHigh;
   assign wrAct = sel && !we_b;
   assign drive = sel && we_b && !oe_b && !rdBlk;
   always @(sel) rdBlk = sel && !we_b;
   always @(negedge wrAct) if (hostOe) mem[addr] = hostData;
   always @(drive or addr) if (drive) last = mem.exists(addr) ? mem[addr] : 8'H00;
   // Released pins show the inverse of the last value
   assign bus   = hostOe ? hostData : (drive ? last : ~last);
   assign clash = hostOe && drive;
endmodule : asrc_sram_model
`default_nettype wire

// ### verification/asrc_host_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "asrc_defines.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
   $display("ERROR %0t: got %h want %h", $time, a, b); end end
module asrc_host_test;
   logic                    clk_sys = 1'b0;
   logic                    rst_b = 1'b0;
   logic                    reqValid = 1'b0;
   logic                    reqWrite = 1'b0;
   logic [`ASRC_ADDR_W-1:0] reqAddr = '0;
   logic [`ASRC_ADDR_W-1:0] memAddr;
   logic [`ASRC_ADDR_W-1:0] lastAddr = '0;
   logic [`ASRC_DATA_W-1:0] reqData = '0;
   logic [`ASRC_DATA_W-1:0] rspData;
   logic [`ASRC_DATA_W-1:0] memDataIn;
   logic [`ASRC_DATA_W-1:0] memDataOut;
   logic                    reqReady, rspValid, selectActiveLow_b;
   logic                    selectActiveHigh, writeStrobe_b, outputGate_b;
   logic                    memDataOe, clash, allAct;
   logic                    lastAct = 1'b0;
   int                      failures = 0;
   int                      check_count = 0;
   asrc_host u_asrc_host (.clk_sys(clk_sys), .rst_b(rst_b),
      .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
      .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid),
      .rspData(rspData), .memAddr(memAddr),
      .selectActiveLow_b(selectActiveLow_b),
      .selectActiveHigh(selectActiveHigh), .writeStrobe_b(writeStrobe_b),
      .outputGate_b(outputGate_b), .memDataIn(memDataIn),
      .memDataOut(memDataOut), .memDataOe(memDataOe));
   asrc_sram_model u_asrc_sram_model (.addr(memAddr),
      .selLow_b(selectActiveLow_b), .selHigh(selectActiveHigh),
      .we_b(writeStrobe_b), .oe_b(outputGate_b), .hostData(memDataOut),
      .hostOe(memDataOe), .bus(memDataIn), .clash(clash));
   initial forever #12.5 clk_sys = ~clk_sys;
   assign allAct = !selectActiveLow_b && selectActiveHigh && !writeStrobe_b;
   // Pin watch on every cycle once rst_b is released
   always @(negedge clk_sys) if (rst_b) begin
      `CHK(clash, 1'b0)
      if (!outputGate_b) `CHK(writeStrobe_b, 1'b1)
      if (memDataOe) `CHK(outputGate_b, 1'b1)
      if (memAddr !== lastAddr) `CHK(allAct | lastAct, 1'b0)
      lastAddr = memAddr;
      lastAct = allAct;
   end
   task test_done;
      if (failures == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   task waitk(input bit rsp, output int k);
      k = 0;
      do begin
         @(negedge clk_sys);
         k++;
      end while ((rsp ? rspValid : reqReady) !== 1'b1 && k < 40);
      if (k >= 40) begin
         failures++;
         $display("ERROR %0t: timeout", $time);
         test_done;
      end
   endtask : waitk
   task issue(input bit w, input logic [16:0] a, input logic [7:0] d,
              output int k);
      @(posedge clk_sys);
      reqValid <= 1'b1;
      reqWrite <= w;
      reqAddr <= a;
      reqData <= d;
      waitk(1'b0, k);
      @(posedge clk_sys);
      reqValid <= 1'b0;
      waitk(!w, k);
   endtask : issue
   task wr(input logic [16:0] a, input logic [7:0] d);
      int k;
      issue(1'b1, a, d, k);
      `CHK(k, 7)
   endtask : wr
   task rd(input logic [16:0] a, input logic [7:0] e);
      int k;
      issue(1'b0, a, 8'H00, k);
      `CHK(k, 8)
      `CHK(rspData, e)
      waitk(1'b0, k);
      `CHK(k, 2)
   endtask : rd
   task scn_reset;
      @(negedge clk_sys);
      `CHK({reqReady, selectActiveLow_b, selectActiveHigh, writeStrobe_b,
            outputGate_b, memDataOe, rspValid}, 7'H6C)
   endtask : scn_reset
   task scn_write_read;
      wr(17'H00123, 8'HA5);
      rd(17'H00123, 8'HA5);
   endtask : scn_write_read
   task scn_bounds;
      wr(17'H00000, 8'HFF);
      wr(17'H1FFFF, 8'H00);
      rd(17'H00000, 8'HFF);
      rd(17'H1FFFF, 8'H00);
   endtask : scn_bounds
   task scn_overwrite;
      wr(17'H0ABCD, 8'H3C);
      wr(17'H0ABCD, 8'HC3);
      rd(17'H0ABCD, 8'HC3);
      rd(17'H00123, 8'HA5);
   endtask : scn_overwrite
   initial begin
      repeat (10) @(posedge clk_sys);
      scn_reset;
      @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      scn_write_read;
      scn_bounds;
      scn_overwrite;
      test_done;
   end
endmodule : asrc_host_test
`default_nettype wire
